//--- rtl/nph_cfg.svh
`ifndef NPH_CFG_SVH
`define NPH_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define NPH_UC_DIV 4
`define NPH_BOOT_SKIP 2'h2
`define NPH_BR_UCYC 3'h4

// ----------------------------------------
// number format
// ----------------------------------------
`define NPH_MDC_RST 4'h8
`define NPH_MDC_MAX 8
`define NPH_NREG 5
`define NPH_NSLOT 12
`define NPH_REG_X 3'h0
`define NPH_SLOT_EXP0 4'h8
`define NPH_SLOT_EXP1 4'h9
`define NPH_SLOT_DP 4'hA
`define NPH_SLOT_SIGN 4'hB
`define NPH_TAIL_FLT 4'h2
`define NPH_TAIL_SCI 4'h4

// ----------------------------------------
// shared input line fields
// ----------------------------------------
`define NPH_BIT_JC 5
`define NPH_BIT_ADR_N 4

// ----------------------------------------
// opcodes
// ----------------------------------------
`define NPH_OP_TOGGLE 6'h30
`define NPH_OP_SETMDC 6'h31
`define NPH_OP_BLKLOAD 6'h32
`define NPH_OP_BLKSTORE 6'h33
`define NPH_OP_DIGLOAD 6'h34
`define NPH_OP_FCLR 6'h35
`define NPH_OP_FTEST 6'h36
`define NPH_OP_TJUMP 6'h37
`define NPH_OP_SETF1 6'h38
`define NPH_OP_SETF2 6'h39
`define NPH_OP_PULF1 6'h3A
`define NPH_OP_PULF2 6'h3B
`define NPH_OP_INV 6'h3C

`endif

//--- rtl/nph_pkg.sv
package nph_pkg;

    typedef enum logic [3:0] {
        ST_GAP = 4'h0,
        ST_FETCH = 4'h1,
        ST_EXEC = 4'h2,
        ST_BLK = 4'h3,
        ST_AIN = 4'h4,
        ST_ACK = 4'h5,
        ST_TJC = 4'h6,
        ST_BR = 4'h7
    } nph_state_t;

    typedef struct packed {
        nph_state_t st;
        logic [1:0] boot;
        logic word2;
        logic [5:0] op;
        logic rdy;
        logic input_bus_select;
        logic br_n;
        logic [2:0] br_cnt;
        logic [3:0] didx;
        logic das_n;
        logic [3:0] dout;
        logic dw_n;
        logic f1;
        logic f2;
        logic fault;
        logic sci;
        logic [3:0] mdc;
        logic [2:0] ain_idx;
        logic [3:0] k;
        logic [1:0] ph;
        logic [1:0] pmask;
    } nph_ctl_t;

endpackage : nph_pkg

//--- rtl/nph_ucycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "nph_cfg.svh"

module nph_ucycle #(
    parameter int DIV = `NPH_UC_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o,
    output logic sync_n_o
);
    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
        logic sync_n;
    } nph_uc_t;

    nph_uc_t s_r;
    nph_uc_t s_nxt;

    generate
        if (DIV != 4) begin : g_bad_div
            $error("nph_ucycle: divider must be 4");
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = s_r.cnt + 2'h1;
        s_nxt.tick = (s_r.cnt == 2'h3);
        s_nxt.sync_n = ~(s_r.cnt == 2'h3);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '{cnt: 2'h0, tick: 1'b0, sync_n: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;
    assign sync_n_o = s_r.sync_n;
endmodule : nph_ucycle
`default_nettype wire

//--- rtl/nph_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "nph_cfg.svh"

module nph_regfile #(
    parameter int NREG = `NPH_NREG,
    parameter int NSLOT = `NPH_NSLOT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] rd_reg_i,
    input wire logic [3:0] rd_slot_i,
    output logic [3:0] rd_data_o,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_reg_i,
    input wire logic [3:0] wr_slot_i,
    input wire logic [3:0] wr_data_i
);
    // slots 0..7 mantissa, 8..9 exponent, 10 point, 11 signs
    typedef struct packed {
        logic [NREG-1:0][NSLOT-1:0][3:0] mem;
    } nph_rf_t;

    nph_rf_t s_r;
    nph_rf_t s_nxt;

    generate
        if (NREG < 1 || NREG > 8 || NSLOT != 12) begin : g_bad_size
            $error("nph_regfile: unsupported size");
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        if (wr_en_i && 32'(wr_reg_i) < NREG && 32'(wr_slot_i) < NSLOT) begin
            s_nxt.mem[wr_reg_i][wr_slot_i] = wr_data_i;
        end
        rd_data_o = 4'h0;
        if (32'(rd_reg_i) < NREG && 32'(rd_slot_i) < NSLOT) begin
            rd_data_o = s_r.mem[rd_reg_i][rd_slot_i];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : nph_regfile
`default_nettype wire

//--- rtl/nph_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nph_cfg.svh"

// Functional notes
// - sync strobe low once per four clocks
// - after reset, two fetch pulses before first opcode
// - bus select high for opcode, low for data
// - fetch request stays high while stall held
// - stall low: drop request, take opcode, execute
// - true test: four-microcycle low branch strobe
// - five numeric registers with digits, point, signs
// - float transfer: mantissa, sign digit, point digit
// - scientific: mantissa, exponent, signs, point digit
// - float after reset, toggle op flips notation
// - mantissa count resets eight, settable one-eight
// - digit index steps through each transferred digit
// - store: BCD out, one write strobe per digit
// - load: index strobe low before each read
// - single-digit loads index zero to seven, accumulate
// - single-digit load waits for valid low
// - invert flag two for one microcycle after digit read
// - fault set on error, cleared by clear op
// - flags set or pulsed by their ops
// - jump test branches when condition high
// - two-word ops give two fetch pulses
// - count word is BCD one to eight
// - digit index zero after every transfer
module nph_top #(
    parameter int MDC_MAX = `NPH_MDC_MAX
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] opcode_lines_i,
    input wire logic fetch_stall_i,
    input wire logic error_event_i,
    output logic microcycle_strobe_n_o,
    output logic fetch_request_o,
    output logic input_bus_select_o,
    output logic branch_strobe_n_o,
    output logic [3:0] digit_index_o,
    output logic digit_index_strobe_n_o,
    output logic [3:0] digit_out_o,
    output logic digit_write_strobe_n_o,
    output logic user_flag_one_o,
    output logic user_flag_two_o,
    output logic fault_o
);
    import nph_pkg::*;

    nph_ctl_t s_r;
    nph_ctl_t s_nxt;
    logic tick;
    logic [3:0] rd_data;
    logic wr_en;
    logic [3:0] wr_slot;
    logic [3:0] wr_data;
    logic [3:0] cur_slot;
    logic [3:0] total;

    generate
        if (MDC_MAX < 1 || MDC_MAX > 8) begin : g_bad_mdc
            $error("nph_top: mantissa count limit must be 1..8");
        end
    endgenerate

    // ----------------------------------------
    // microcycle timebase and number storage
    // ----------------------------------------
    nph_ucycle u_ucycle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick),
        .sync_n_o(microcycle_strobe_n_o)
    );

    nph_regfile u_regfile (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rd_reg_i(`NPH_REG_X),
        .rd_slot_i(cur_slot),
        .rd_data_o(rd_data),
        .wr_en_i(wr_en),
        .wr_reg_i(`NPH_REG_X),
        .wr_slot_i(wr_slot),
        .wr_data_i(wr_data)
    );

    // ----------------------------------------
    // transfer order
    // ----------------------------------------
    function automatic logic [3:0] slot_of(
        input logic [3:0] k,
        input logic [3:0] mdc,
        input logic sci
    );
        logic [3:0] j;
        j = k - mdc;
        if (k < mdc) begin
            slot_of = k;
        end else if (!sci) begin
            slot_of = (j == 4'h0) ? `NPH_SLOT_SIGN : `NPH_SLOT_DP;
        end else begin
            case (j)
                4'h0: slot_of = `NPH_SLOT_EXP0;
                4'h1: slot_of = `NPH_SLOT_EXP1;
                4'h2: slot_of = `NPH_SLOT_SIGN;
                default: slot_of = `NPH_SLOT_DP;
            endcase
        end
    endfunction : slot_of

    assign cur_slot = slot_of(s_r.k, s_r.mdc, s_r.sci);
    assign total = s_r.mdc + (s_r.sci ? `NPH_TAIL_SCI : `NPH_TAIL_FLT);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        wr_en = 1'b0;
        wr_slot = cur_slot;
        wr_data = opcode_lines_i[3:0];
        // everything except the error-driven fault set advances on microcycle boundaries only
        if (tick) begin
            if (s_r.br_cnt != 3'h0) begin
                s_nxt.br_cnt = s_r.br_cnt - 3'h1;
                if (s_r.br_cnt == 3'h1) begin
                    s_nxt.br_n = 1'b1;
                end
            end
            unique case (s_r.st)
                ST_GAP: begin
                    s_nxt.st = ST_FETCH;
                    s_nxt.rdy = 1'b1;
                    s_nxt.input_bus_select = 1'b1;
                end
                ST_FETCH: begin
                    // request holds while stall is high
                    if (!fetch_stall_i) begin
                        s_nxt.rdy = 1'b0;
                        s_nxt.st = ST_GAP;
                        if (s_r.boot != 2'h0) begin
                            s_nxt.boot = s_r.boot - 2'h1;
                        end else if (s_r.word2) begin
                            s_nxt.word2 = 1'b0;
                            if (s_r.op == `NPH_OP_SETMDC) begin
                                if (opcode_lines_i[3:0] >= 4'h1 &&
                                    32'(opcode_lines_i[3:0]) <= MDC_MAX) begin
                                    s_nxt.mdc = opcode_lines_i[3:0];
                                end else begin
                                    s_nxt.fault = 1'b1;
                                end
                            end else if (s_r.op == `NPH_OP_BLKLOAD ||
                                         s_r.op == `NPH_OP_BLKSTORE) begin
                                s_nxt.st = ST_BLK;
                                s_nxt.k = 4'h0;
                                s_nxt.ph = 2'h0;
                                s_nxt.didx = 4'h0;
                                s_nxt.input_bus_select = (s_r.op != `NPH_OP_BLKLOAD);
                            end
                        end else begin
                            s_nxt.op = opcode_lines_i;
                            s_nxt.st = ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    s_nxt.st = ST_GAP;
                    // any other op ends accumulation of single digits
                    s_nxt.ain_idx = 3'h0;
                    case (s_r.op)
                        `NPH_OP_TOGGLE: s_nxt.sci = ~s_r.sci;
                        `NPH_OP_SETMDC,
                        `NPH_OP_BLKLOAD,
                        `NPH_OP_BLKSTORE,
                        `NPH_OP_INV: s_nxt.word2 = 1'b1;
                        `NPH_OP_DIGLOAD: begin
                            s_nxt.ain_idx = s_r.ain_idx;
                            s_nxt.input_bus_select = 1'b0;
                            s_nxt.didx = {1'b0, s_r.ain_idx};
                            s_nxt.st = ST_AIN;
                        end
                        `NPH_OP_FCLR: s_nxt.fault = 1'b0;
                        `NPH_OP_FTEST: begin
                            s_nxt.word2 = 1'b1;
                            if (s_r.fault) begin
                                s_nxt.br_n = 1'b0;
                                s_nxt.br_cnt = `NPH_BR_UCYC;
                                s_nxt.st = ST_BR;
                            end
                        end
                        `NPH_OP_TJUMP: begin
                            s_nxt.input_bus_select = 1'b0;
                            s_nxt.st = ST_TJC;
                        end
                        `NPH_OP_SETF1: s_nxt.f1 = 1'b1;
                        `NPH_OP_SETF2: s_nxt.f2 = 1'b1;
                        `NPH_OP_PULF1: begin
                            s_nxt.f1 = ~s_r.f1;
                            s_nxt.pmask = 2'h1;
                            s_nxt.st = ST_ACK;
                        end
                        `NPH_OP_PULF2: begin
                            s_nxt.f2 = ~s_r.f2;
                            s_nxt.pmask = 2'h2;
                            s_nxt.st = ST_ACK;
                        end
                        default: s_nxt.st = ST_GAP;
                    endcase
                end
                ST_TJC: begin
                    // lines were in data phase for a full microcycle
                    s_nxt.input_bus_select = 1'b1;
                    s_nxt.word2 = 1'b1;
                    s_nxt.st = ST_GAP;
                    if (opcode_lines_i[`NPH_BIT_JC]) begin
                        s_nxt.br_n = 1'b0;
                        s_nxt.br_cnt = `NPH_BR_UCYC;
                        s_nxt.st = ST_BR;
                    end
                end
                ST_BR: begin
                    // request rises inside the last strobe microcycle
                    if (s_r.br_cnt == 3'h2) begin
                        s_nxt.st = ST_FETCH;
                        s_nxt.rdy = 1'b1;
                    end
                end
                ST_AIN: begin
                    if (!opcode_lines_i[`NPH_BIT_ADR_N]) begin
                        wr_en = 1'b1;
                        wr_slot = {1'b0, s_r.ain_idx};
                        s_nxt.f2 = ~s_r.f2;
                        s_nxt.pmask = 2'h2;
                        s_nxt.input_bus_select = 1'b1;
                        s_nxt.st = ST_ACK;
                        // digits past the eighth overwrite the last slot
                        if (s_r.ain_idx != 3'h7) begin
                            s_nxt.ain_idx = s_r.ain_idx + 3'h1;
                        end
                    end
                end
                ST_ACK: begin
                    s_nxt.f1 = s_r.f1 ^ s_r.pmask[0];
                    s_nxt.f2 = s_r.f2 ^ s_r.pmask[1];
                    s_nxt.didx = 4'h0;
                    s_nxt.st = ST_GAP;
                end
                ST_BLK: begin
                    s_nxt.ph = s_r.ph + 2'h1;
                    unique case (s_r.ph)
                        2'h0: begin
                            if (s_r.op == `NPH_OP_BLKSTORE) begin
                                s_nxt.dout = rd_data;
                            end else begin
                                s_nxt.das_n = 1'b0;
                            end
                        end
                        2'h1: begin
                            if (s_r.op == `NPH_OP_BLKSTORE) begin
                                s_nxt.dw_n = 1'b0;
                            end else begin
                                s_nxt.das_n = 1'b1;
                            end
                        end
                        2'h2: begin
                            if (s_r.op == `NPH_OP_BLKSTORE) begin
                                s_nxt.dw_n = 1'b1;
                            end else begin
                                wr_en = 1'b1;
                            end
                        end
                        2'h3: begin
                            if (s_r.k + 4'h1 == total) begin
                                s_nxt.didx = 4'h0;
                                s_nxt.dout = 4'h0;
                                s_nxt.input_bus_select = 1'b1;
                                s_nxt.st = ST_GAP;
                            end else begin
                                s_nxt.k = s_r.k + 4'h1;
                                s_nxt.didx = s_r.k + 4'h1;
                            end
                        end
                    endcase
                end
                default: s_nxt.st = ST_GAP;
            endcase
        end
        // a new error wins over a clear in the same cycle
        if (error_event_i) begin
            s_nxt.fault = 1'b1;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '{
                st: ST_GAP,
                boot: `NPH_BOOT_SKIP,
                word2: 1'b0,
                op: 6'h00,
                rdy: 1'b0,
                input_bus_select: 1'b0,
                br_n: 1'b1,
                br_cnt: 3'h0,
                didx: 4'h0,
                das_n: 1'b1,
                dout: 4'h0,
                dw_n: 1'b1,
                f1: 1'b0,
                f2: 1'b0,
                fault: 1'b0,
                sci: 1'b0,
                mdc: `NPH_MDC_RST,
                ain_idx: 3'h0,
                k: 4'h0,
                ph: 2'h0,
                pmask: 2'h0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fetch_request_o = s_r.rdy;
    assign input_bus_select_o = s_r.input_bus_select;
    assign branch_strobe_n_o = s_r.br_n;
    assign digit_index_o = s_r.didx;
    assign digit_index_strobe_n_o = s_r.das_n;
    assign digit_out_o = s_r.dout;
    assign digit_write_strobe_n_o = s_r.dw_n;
    assign user_flag_one_o = s_r.f1;
    assign user_flag_two_o = s_r.f2;
    assign fault_o = s_r.fault;
endmodule : nph_top
`default_nettype wire

//--- tb/nph_checker.sv
`timescale 1ns/1ps
`default_nettype none
module nph_checker #(
    parameter int MDC_MAX = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fetch_stall_i,
    input wire logic error_event_i,
    input wire logic microcycle_strobe_n_o,
    input wire logic fetch_request_o,
    input wire logic input_bus_select_o,
    input wire logic branch_strobe_n_o,
    input wire logic [3:0] digit_index_o,
    input wire logic digit_index_strobe_n_o,
    input wire logic [3:0] digit_out_o,
    input wire logic digit_write_strobe_n_o,
    input wire logic fault_o
);
    logic [4:0] br_len_r;
    logic take_ok_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----
    // branch length and take-window helpers
    // ----
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            br_len_r <= 5'h00;
            take_ok_r <= 1'b0;
        end else begin
            br_len_r <= branch_strobe_n_o ? 5'h00 : br_len_r + 5'h01;
            take_ok_r <= !microcycle_strobe_n_o && !fetch_stall_i;
        end
    end
    property p_sync;
        !microcycle_strobe_n_o |=> microcycle_strobe_n_o[*3] ##1 !microcycle_strobe_n_o;
    endproperty
    property p_hold;
        fetch_request_o && fetch_stall_i && !microcycle_strobe_n_o |=> fetch_request_o;
    endproperty
    property p_drop;
        fetch_request_o && !fetch_stall_i && !microcycle_strobe_n_o |=> !fetch_request_o;
    endproperty
    property p_drop_cause;
        $fell(fetch_request_o) |-> take_ok_r;
    endproperty
    property p_br_len;
        $rose(branch_strobe_n_o) |-> br_len_r == 5'h10 && $past(fetch_request_o);
    endproperty
    property p_input_bus_select;
        fetch_request_o |-> input_bus_select_o;
    endproperty
    property p_write;
        $fell(digit_write_strobe_n_o) |=> !digit_write_strobe_n_o[*3] ##1 digit_write_strobe_n_o;
    endproperty
    property p_write_data;
        !digit_write_strobe_n_o |-> $stable(digit_out_o) && $stable(digit_index_o);
    endproperty
    property p_das;
        $rose(digit_index_strobe_n_o) |-> $stable(digit_index_o) && !input_bus_select_o;
    endproperty
    property p_idx_zero;
        $rose(fetch_request_o) |-> digit_index_o == 4'h0 && digit_out_o == 4'h0;
    endproperty
    property p_fault;
        error_event_i |-> ##[1:4] fault_o;
    endproperty
    a_sync: assert property (p_sync) else $error("sync strobe spacing wrong");
    a_hold: assert property (p_hold) else $error("request dropped under stall");
    a_drop: assert property (p_drop) else $error("request not dropped");
    a_drop_cause: assert property (p_drop_cause) else $error("request fell off a take");
    a_br_len: assert property (p_br_len) else $error("branch strobe length wrong");
    a_input_bus_select: assert property (p_input_bus_select) else $error("select low during fetch");
    a_write: assert property (p_write) else $error("write strobe length wrong");
    a_write_data: assert property (p_write_data) else $error("digit moved under write");
    a_das: assert property (p_das) else $error("index strobe rise wrong");
    a_idx_zero: assert property (p_idx_zero) else $error("index not blanked");
    a_fault: assert property (p_fault) else $error("fault not raised");
    c_branch: cover property ($fell(branch_strobe_n_o));
    c_load: cover property ($fell(digit_index_strobe_n_o));
    c_stall: cover property (fetch_request_o && fetch_stall_i);
endmodule : nph_checker
bind nph_top nph_checker #(.MDC_MAX(MDC_MAX)) nph_checker_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fetch_stall_i(fetch_stall_i),
    .error_event_i(error_event_i),
    .microcycle_strobe_n_o(microcycle_strobe_n_o),
    .fetch_request_o(fetch_request_o),
    .input_bus_select_o(input_bus_select_o),
    .branch_strobe_n_o(branch_strobe_n_o),
    .digit_index_o(digit_index_o),
    .digit_index_strobe_n_o(digit_index_strobe_n_o),
    .digit_out_o(digit_out_o),
    .digit_write_strobe_n_o(digit_write_strobe_n_o),
    .fault_o(fault_o)
);
`default_nettype wire

//--- tb/nph_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nph_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fetch_request_i,
    input wire logic input_bus_select_i,
    input wire logic [5:0] word_i,
    input wire logic [5:0] data_i,
    input wire logic [7:0] delay_i,
    output logic fetch_stall_o,
    output logic [5:0] opcode_lines_o
);
    logic req_q;
    logic [7:0] wait_cnt;
    // ----
    // steering and slow source
    // ----
    assign opcode_lines_o = input_bus_select_i ? word_i : data_i;
    // stall is up well before the next microcycle, so a slow word is never taken
    assign fetch_stall_o = (wait_cnt != 8'h00);
    always @(negedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q <= 1'b0;
            wait_cnt <= 8'h00;
        end else begin
            req_q <= fetch_request_i;
            if (fetch_request_i && !req_q) begin
                wait_cnt <= delay_i;
            end else if (wait_cnt != 8'h00) begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end
    end
endmodule : nph_host_model
`default_nettype wire

//--- tb/tb_nph_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nph_cfg.svh"
module tb_nph_top;
    logic clk_i;
    logic rst_i = 1'b1;
    logic err_ev = 1'b0;
    logic [5:0] word = `NPH_OP_PULF1;
    logic [5:0] data = 6'h10;
    logic [7:0] delay = 8'h00;
    logic [5:0] op_lines;
    logic stall, msn, req, input_bus_select, brn, dasn, dwn, f1, f2, fault;
    logic dwn_q, dasn_q, f1_q, f2_q;
    logic [3:0] didx, dout, first_dout;
    int error_cnt = 0;
    int n_tests = 0;
    int br_lo = 0;
    int n_dw = 0;
    int n_das = 0;
    int f1_chg = 0;
    int f2_chg = 0;
    nph_top nph_top_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .opcode_lines_i(op_lines),
        .fetch_stall_i(stall),
        .error_event_i(err_ev),
        .microcycle_strobe_n_o(msn),
        .fetch_request_o(req),
        .input_bus_select_o(input_bus_select),
        .branch_strobe_n_o(brn),
        .digit_index_o(didx),
        .digit_index_strobe_n_o(dasn),
        .digit_out_o(dout),
        .digit_write_strobe_n_o(dwn),
        .user_flag_one_o(f1),
        .user_flag_two_o(f2),
        .fault_o(fault)
    );
    nph_host_model nph_host_model_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fetch_request_i(req),
        .input_bus_select_i(input_bus_select),
        .word_i(word),
        .data_i(data),
        .delay_i(delay),
        .fetch_stall_o(stall),
        .opcode_lines_o(op_lines)
    );
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    // one word per fetch; returns at the falling edge after the take
    task automatic send(input logic [5:0] op);
        int n;
        n = 0;
        word = op;
        while (req !== 1'b1 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        while (req !== 1'b0 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        check("fetch handshake", n < 4000, 1);
    endtask : send
    task automatic pair(input logic [5:0] a, input logic [5:0] b);
        send(a);
        send(b);
        send(6'h00);
    endtask : pair
    // ----
    // strobe monitor
    // ----
    always @(negedge clk_i) begin
        if (!rst_i) begin
            if (brn === 1'b0) br_lo++;
            if (f1 !== f1_q) f1_chg++;
            if (f2 !== f2_q) f2_chg++;
            if (dwn_q === 1'b1 && dwn === 1'b0) begin
                if (n_dw == 0) first_dout = dout;
                check("store index", didx, n_dw);
                n_dw++;
            end
            if (dasn_q === 1'b0 && dasn === 1'b1) begin
                check("load index", didx, n_das);
                n_das++;
            end
        end
        dwn_q = dwn;
        dasn_q = dasn;
        f1_q = f1;
        f2_q = f2;
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        check("idle request", req, 0);
        check("idle outputs", {fault, f1, f2, didx, dout}, 0);
        send(`NPH_OP_PULF1);
        send(`NPH_OP_PULF1);
        check("boot words ignored", f1_chg, 0);
        delay = 8'h0C;
        pair(`NPH_OP_SETF1, `NPH_OP_SETF2);
        pair(`NPH_OP_PULF1, `NPH_OP_PULF2);
        check("flags set", {f1, f2}, 3);
        check("flag pulses", {f1_chg[7:0], f2_chg[7:0]}, 16'h0303);
        err_ev = 1'b1;
        @(negedge clk_i);
        err_ev = 1'b0;
        delay = 8'h00;
        br_lo = 0;
        pair(`NPH_OP_FTEST, 6'h00);
        check("fault set", fault, 1);
        check("fault branch", br_lo, 16);
        br_lo = 0;
        pair(`NPH_OP_FCLR, `NPH_OP_FTEST);
        check("fault clear", {fault, br_lo[4:0]}, 0);
        for (int j = 0; j < 2; j++) begin
            data = j ? 6'h30 : 6'h10;
            br_lo = 0;
            pair(`NPH_OP_TJUMP, `NPH_OP_PULF1);
            check("jump branch", br_lo, j * 16);
        end
        pair(`NPH_OP_INV, `NPH_OP_PULF1);
        check("second word ignored", f1_chg, 3);
        pair(`NPH_OP_SETMDC, 6'h03);
        for (int m = 0; m < 3; m++) begin
            n_dw = 0;
            pair(`NPH_OP_BLKSTORE, 6'h00);
            check("store digits", n_dw, m == 1 ? 7 : 5);
            check("index idle", didx, 0);
            pair(`NPH_OP_TOGGLE, 6'h00);
        end
        pair(`NPH_OP_SETMDC, 6'h09);
        check("bad count fault", fault, 1);
        n_dw = 0;
        pair(`NPH_OP_BLKSTORE, 6'h00);
        check("count kept", n_dw, 7);
        pair(`NPH_OP_FCLR, `NPH_OP_TOGGLE);
        pair(`NPH_OP_SETMDC, 6'h08);
        data = 6'h05;
        n_das = 0;
        pair(`NPH_OP_BLKLOAD, 6'h00);
        check("load digits", n_das, 10);
        n_dw = 0;
        pair(`NPH_OP_BLKSTORE, 6'h00);
        check("stored digit", first_dout, 5);
        // digit loads run back to back: any other op would restart the index
        data = 6'h17;
        send(`NPH_OP_DIGLOAD);
        for (int a = 0; a < 2; a++) begin
            f2_chg = 0;
            repeat (40) @(negedge clk_i);
            check("digit wait", {input_bus_select, f2_chg[3:0], didx}, a);
            data = 6'h07;
            send(a == 0 ? `NPH_OP_DIGLOAD : 6'h00);
            data = 6'h17;
            check("digit ack", f2_chg, 2);
            check("index idle", didx, 0);
        end
        give_verdict();
    end
endmodule : tb_nph_top
`default_nettype wire
